// File: include/brtc_pkg.sv
// package for the bcd timekeeping core: constants, register layout and crossing carriers
// assumes one system clock at 125 MHz and a byte-level two-wire bus engine on its own clock
// Function
// - clock registers 00h-07h, storage bytes 08h-3Fh
// - pointer wraps from 3Fh to 00h
// - time and calendar held in bcd
// - weekday steps at midnight, cycles one to seven
// - seconds bit seven halts oscillator and counting
// - power-up date 01/01/00, weekday 01, halted
// - hours bit six selects twelve-hour mode
// - hours bit five is pm or tens
// - time reads come from shadow captured at start
// - seconds write resets the sub-second divider
// - write byte lands at its acknowledge
// - fixed-zero bits always read as zero
// - wave disabled: pin follows output-level bit
// - control bit four routes divided oscillator out
// - rate field picks 1, 4096, 8192, 32768 hz
// - one hertz wave: counters step on fall
// - control powers up as 03h
// - date rolls at true month end, leap years
// - pointer steps after every data byte
package brtc_pkg;
    localparam int         PTR_W        = 6;
    localparam int         DIV_W        = 15;
    localparam logic [5:0] ADDR_SECONDS = 6'h00;
    localparam logic [5:0] ADDR_MINUTES = 6'h01;
    localparam logic [5:0] ADDR_HOURS   = 6'h02;
    localparam logic [5:0] ADDR_DOW     = 6'h03;
    localparam logic [5:0] ADDR_DATE    = 6'h04;
    localparam logic [5:0] ADDR_MONTH   = 6'h05;
    localparam logic [5:0] ADDR_YEAR    = 6'h06;
    localparam logic [5:0] ADDR_CONTROL = 6'h07;
    localparam logic [5:0] ADDR_RAM_LO  = 6'h08;
    localparam int         RAM_DEPTH    = 56;
    // writable bits of each register; the rest read as zero
    localparam logic [7:0] MASK_SECONDS = 8'hFF;
    localparam logic [7:0] MASK_MINUTES = 8'h7F;
    localparam logic [7:0] MASK_HOURS   = 8'h7F;
    localparam logic [7:0] MASK_DOW     = 8'h07;
    localparam logic [7:0] MASK_DATE    = 8'h3F;
    localparam logic [7:0] MASK_MONTH   = 8'h1F;
    localparam logic [7:0] MASK_YEAR    = 8'hFF;
    localparam logic [7:0] MASK_CONTROL = 8'h93;
    // field positions
    localparam int         BIT_HALT     = 7;
    localparam int         BIT_MODE12   = 6;
    localparam int         BIT_PM       = 5;
    localparam int         BIT_OUT      = 7;
    localparam int         BIT_WAVE_EN  = 4;
    localparam int         TAP_4K       = 2;
    localparam int         TAP_8K       = 1;
    // rate select codes
    localparam logic [1:0] RATE_1HZ     = 2'h0;
    localparam logic [1:0] RATE_4K      = 2'h1;
    localparam logic [1:0] RATE_8K      = 2'h2;
    localparam logic [1:0] RATE_32K     = 2'h3;
    // bcd limits
    localparam logic [7:0] BCD_59       = 8'h59;
    localparam logic [7:0] BCD_23       = 8'h23;
    localparam logic [7:0] BCD_12       = 8'h12;
    localparam logic [7:0] BCD_11       = 8'h11;
    localparam logic [7:0] BCD_99       = 8'h99;
    localparam logic [7:0] BCD_ONE      = 8'h01;
    localparam logic [7:0] DOW_LAST     = 8'h07;
    localparam logic [7:0] FEB          = 8'h02;
    localparam logic [7:0] APR          = 8'h04;
    localparam logic [7:0] JUN          = 8'h06;
    localparam logic [7:0] SEP          = 8'h09;
    localparam logic [7:0] NOV          = 8'h11;
    localparam logic [7:0] DAYS_28      = 8'h28;
    localparam logic [7:0] DAYS_29      = 8'h29;
    localparam logic [7:0] DAYS_30      = 8'h30;
    localparam logic [7:0] DAYS_31      = 8'h31;
    // power-up values
    localparam logic [7:0] RST_SECONDS  = 8'h80;
    localparam logic [7:0] RST_CONTROL  = 8'h03;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] dow;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } brtc_time_s;

    localparam brtc_time_s RST_TIME = '{year: 8'h00, month: 8'h01, date: 8'h01, dow: 8'h01,
                                        hours: 8'h00, minutes: 8'h00, seconds: RST_SECONDS};

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } brtc_wr_s;
endpackage

// File: logic/brtc_core.sv
// timekeeping core, square-wave driver and register space of the serial clock
// assumes a byte-level bus engine on link_clk and a 32.768 kHz oscillator level on osc_in
`timescale 1ns/1ps
module brtc_core
    import brtc_pkg::*;
#(
    parameter int DIV_BITS = DIV_W
) (
    input  wire logic       ref_clk,          // 125 MHz system clock
    input  wire logic       rst,              // synchronous reset, active high
    input  wire logic       osc_in,           // 32.768 kHz oscillator level, asynchronous
    input  wire logic       link_clk,         // bus engine clock
    input  wire logic       bus_start,        // start condition seen, pulse
    input  wire logic       ptr_load,         // word address byte received, pulse
    input  wire logic [7:0] ptr_value,        // word address byte
    input  wire logic       wr_valid,         // data byte acknowledged, pulse
    input  wire logic [7:0] wr_byte,          // data byte written
    input  wire logic       rd_next,          // read byte shifted out, pulse
    output logic      [7:0] rd_byte,          // byte at the pointer
    output logic            link_busy,        // write still crossing to the core
    output logic            square_wave_o,    // open-drain data, always low
    output logic            square_wave_oe_n  // low while the pin is pulled low
);
    // ---------------- link domain ----------------
    logic                 lrst_s1_reg;
    logic                 lrst_reg;
    logic [PTR_W-1:0]     ptr_reg;
    logic [7:0]           ram [RAM_DEPTH];
    brtc_time_s           shadow_reg;
    logic [7:0]           ctrl_copy_reg;
    logic                 snap_tgl_reg;
    logic                 wr_tgl_reg;
    brtc_wr_s             wr_hold_reg;
    logic [2:0]           snap_ack_l_reg;
    logic [1:0]           wr_ack_l_reg;
    logic [7:0]           rd_byte_reg;
    logic                 link_busy_reg;
    logic [PTR_W-1:0]     ram_idx;
    logic [55:0]          shadow_bits;

    // ---------------- core domain ----------------
    logic [1:0]           osc_s_reg;
    logic                 osc_d_reg;
    logic [DIV_BITS-1:0]  div_reg;
    logic [DIV_BITS-1:0]  div_next;
    brtc_time_s           time_reg;
    brtc_time_s           time_next;
    logic [7:0]           ctrl_reg;
    brtc_time_s           snap_reg;
    logic [2:0]           snap_req_c_reg;
    logic                 snap_ack_reg;
    logic [2:0]           wr_req_c_reg;
    logic                 wr_ack_reg;
    logic                 osc_rise;
    logic                 tick;
    logic                 wr_apply;
    logic                 wave_level;
    logic                 pin_level_reg;
    logic                 sq_o_reg;

    function automatic logic [7:0] bcd_inc(input logic [7:0] x);
        if (x[3:0] == 4'h9) begin
            bcd_inc = {x[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = x + 8'h01;
        end
    endfunction

    function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (mon == FEB) begin
            month_end = leap ? DAYS_29 : DAYS_28;
        end else if (mon == APR || mon == JUN || mon == SEP || mon == NOV) begin
            month_end = DAYS_30;
        end else begin
            month_end = DAYS_31;
        end
    endfunction

    // link reset follows the system reset through two stages
    always_ff @(posedge link_clk) begin
        lrst_s1_reg <= rst;
        lrst_reg    <= lrst_s1_reg;
    end

    // register pointer
    always_ff @(posedge link_clk) begin
        if (lrst_reg) begin
            ptr_reg <= '0;
        end else if (ptr_load) begin
            ptr_reg <= ptr_value[PTR_W-1:0];
        end else if (wr_valid || rd_next) begin
            ptr_reg <= ptr_reg + 6'h01;
        end
    end

    assign ram_idx = ptr_reg - ADDR_RAM_LO;

    // general storage
    always_ff @(posedge link_clk) begin
        if (wr_valid && ptr_reg >= ADDR_RAM_LO) begin
            ram[ram_idx] <= wr_byte;
        end
    end

    // time writes cross to the core; control copy serves reads on this side
    always_ff @(posedge link_clk) begin
        if (lrst_reg) begin
            wr_tgl_reg    <= 1'b0;
            wr_hold_reg   <= '0;
            ctrl_copy_reg <= RST_CONTROL;
        end else if (wr_valid && ptr_reg < ADDR_RAM_LO) begin
            wr_tgl_reg       <= ~wr_tgl_reg;
            wr_hold_reg.addr <= ptr_reg;
            wr_hold_reg.data <= wr_byte;
            if (ptr_reg == ADDR_CONTROL) begin
                ctrl_copy_reg <= wr_byte & MASK_CONTROL;
            end
        end
    end

    // snapshot request at every start, shadow loaded when the core answers
    always_ff @(posedge link_clk) begin
        if (lrst_reg) begin
            snap_tgl_reg   <= 1'b0;
            snap_ack_l_reg <= '0;
            wr_ack_l_reg   <= '0;
            shadow_reg     <= RST_TIME;
        end else begin
            snap_ack_l_reg <= {snap_ack_l_reg[1:0], snap_ack_reg};
            wr_ack_l_reg   <= {wr_ack_l_reg[0], wr_ack_reg};
            if (bus_start) begin
                snap_tgl_reg <= ~snap_tgl_reg;
            end
            if (snap_ack_l_reg[2] != snap_ack_l_reg[1]) begin
                shadow_reg <= snap_reg;
            end
        end
    end

    assign shadow_bits = shadow_reg;

    // read byte and busy flag
    always_ff @(posedge link_clk) begin
        if (lrst_reg) begin
            rd_byte_reg   <= '0;
            link_busy_reg <= 1'b0;
        end else begin
            link_busy_reg <= wr_tgl_reg != wr_ack_l_reg[1];
            if (ptr_reg >= ADDR_RAM_LO) begin
                rd_byte_reg <= ram[ram_idx];
            end else if (ptr_reg == ADDR_CONTROL) begin
                rd_byte_reg <= ctrl_copy_reg;
            end else begin
                rd_byte_reg <= shadow_bits[{ptr_reg[2:0], 3'h0} +: 8];
            end
        end
    end

    assign rd_byte   = rd_byte_reg;
    assign link_busy = link_busy_reg;

    // ---------------- core domain logic ----------------

    // requests from the link side
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            snap_req_c_reg <= '0;
            wr_req_c_reg   <= '0;
            snap_ack_reg   <= 1'b0;
            wr_ack_reg     <= 1'b0;
            snap_reg       <= RST_TIME;
        end else begin
            snap_req_c_reg <= {snap_req_c_reg[1:0], snap_tgl_reg};
            wr_req_c_reg   <= {wr_req_c_reg[1:0], wr_tgl_reg};
            if (snap_req_c_reg[2] != snap_req_c_reg[1]) begin
                snap_reg     <= time_reg;
                snap_ack_reg <= snap_req_c_reg[1];
            end
            if (wr_apply) begin
                wr_ack_reg <= wr_req_c_reg[1];
            end
        end
    end

    assign wr_apply = wr_req_c_reg[2] != wr_req_c_reg[1];

    // oscillator sampling
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osc_s_reg <= '0;
            osc_d_reg <= 1'b0;
        end else begin
            osc_s_reg <= {osc_s_reg[0], osc_in};
            osc_d_reg <= osc_s_reg[1];
        end
    end

    assign osc_rise = osc_s_reg[1] && !osc_d_reg;
    assign tick     = osc_rise && !time_reg.seconds[BIT_HALT] && (&div_reg);

    // divider chain
    always_comb begin
        div_next = div_reg;
        if (wr_apply && wr_hold_reg.addr == ADDR_SECONDS) begin
            div_next = '0;
        end else if (osc_rise && !time_reg.seconds[BIT_HALT]) begin
            div_next = div_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    // calendar cascade, then a pending write overrides its own field
    always_comb begin
        logic carry;
        logic mode12;
        logic [7:0] hr;
        logic [7:0] sec_up;
        logic [7:0] hr_up;
        time_next = time_reg;
        carry     = 1'b0;
        mode12    = time_reg.hours[BIT_MODE12];
        hr        = {3'h0, time_reg.hours[4:0]};
        sec_up    = bcd_inc(time_reg.seconds);
        hr_up     = bcd_inc({2'h0, time_reg.hours[5:0]});

        if (tick) begin
            if (time_reg.seconds[6:0] == BCD_59[6:0]) begin
                time_next.seconds[6:0] = '0;
                carry = 1'b1;
            end else begin
                time_next.seconds[6:0] = sec_up[6:0];
            end

            if (carry) begin
                carry = time_reg.minutes == BCD_59;
                time_next.minutes = carry ? 8'h00 : bcd_inc(time_reg.minutes);
            end

            if (carry) begin
                if (mode12) begin
                    carry = 1'b0;
                    if (hr == BCD_12) begin
                        hr = BCD_ONE;
                    end else if (hr == BCD_11) begin
                        hr = BCD_12;
                        carry = time_reg.hours[BIT_PM];
                        time_next.hours[BIT_PM] = ~time_reg.hours[BIT_PM];
                    end else begin
                        hr = bcd_inc(hr);
                    end
                    time_next.hours[4:0] = hr[4:0];
                end else begin
                    carry = time_reg.hours[5:0] == BCD_23[5:0];
                    time_next.hours[5:0] = carry ? 6'h00 : hr_up[5:0];
                end
            end

            if (carry) begin
                time_next.dow = (time_reg.dow == DOW_LAST) ? BCD_ONE : time_reg.dow + 8'h01;
                if (time_reg.date == month_end(time_reg.month, time_reg.year)) begin
                    time_next.date = BCD_ONE;
                    if (time_reg.month == BCD_12) begin
                        time_next.month = BCD_ONE;
                        time_next.year  = (time_reg.year == BCD_99) ? 8'h00 : bcd_inc(time_reg.year);
                    end else begin
                        time_next.month = bcd_inc(time_reg.month);
                    end
                end else begin
                    time_next.date = bcd_inc(time_reg.date);
                end
            end
        end

        if (wr_apply) begin
            unique case (wr_hold_reg.addr)
                ADDR_SECONDS: time_next.seconds = wr_hold_reg.data & MASK_SECONDS;
                ADDR_MINUTES: time_next.minutes = wr_hold_reg.data & MASK_MINUTES;
                ADDR_HOURS:   time_next.hours   = wr_hold_reg.data & MASK_HOURS;
                ADDR_DOW:     time_next.dow     = wr_hold_reg.data & MASK_DOW;
                ADDR_DATE:    time_next.date    = wr_hold_reg.data & MASK_DATE;
                ADDR_MONTH:   time_next.month   = wr_hold_reg.data & MASK_MONTH;
                ADDR_YEAR:    time_next.year    = wr_hold_reg.data & MASK_YEAR;
                default:      time_next = time_next;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            time_reg <= RST_TIME;
        end else begin
            time_reg <= time_next;
        end
    end

    // square-wave control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_reg <= RST_CONTROL;
        end else if (wr_apply && wr_hold_reg.addr == ADDR_CONTROL) begin
            ctrl_reg <= wr_hold_reg.data & MASK_CONTROL;
        end
    end

    // wave source; the one-hertz wave falls exactly when the divider wraps
    always_comb begin
        unique case (ctrl_reg[1:0])
            RATE_1HZ: wave_level = div_reg[DIV_BITS-1];
            RATE_4K:  wave_level = div_reg[TAP_4K];
            RATE_8K:  wave_level = div_reg[TAP_8K];
            RATE_32K: wave_level = osc_d_reg && !time_reg.seconds[BIT_HALT];
        endcase
    end

    // open-drain pin: pulled low when the level is 0
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_level_reg <= 1'b0;
            sq_o_reg      <= 1'b0;
        end else begin
            sq_o_reg      <= 1'b0;
            if (ctrl_reg[BIT_WAVE_EN]) begin
                pin_level_reg <= wave_level;
            end else begin
                pin_level_reg <= ctrl_reg[BIT_OUT];
            end
        end
    end

    assign square_wave_o    = sq_o_reg;
    assign square_wave_oe_n = pin_level_reg;
endmodule

// File: test/brtc_core_asserts.sv
// port checker for the bcd timekeeping core
// assumes binding into brtc_core; pointer and control are mirrored from the bus pulses
`timescale 1ns/1ps
module brtc_core_asserts
    import brtc_pkg::*;
(
    input wire logic       ref_clk,          // core clock
    input wire logic       rst,              // reset
    input wire logic       osc_in,           // oscillator
    input wire logic       link_clk,         // link clock
    input wire logic       bus_start,        // start pulse
    input wire logic       ptr_load,         // address pulse
    input wire logic [7:0] ptr_value,        // address byte
    input wire logic       wr_valid,         // write pulse
    input wire logic [7:0] wr_byte,          // write byte
    input wire logic       rd_next,          // read advance
    input wire logic [7:0] rd_byte,          // read byte
    input wire logic       link_busy,        // write crossing
    input wire logic       square_wave_o,    // pin data
    input wire logic       square_wave_oe_n  // pin enable
);
    logic [5:0] ptr_reg;
    logic [7:0] ctl_reg;
    logic [2:0] quiet_reg;
    logic [7:0] ctl_s1_reg;
    logic [7:0] ctl_s2_reg;
    logic [4:0] hold_reg;

    function automatic logic [7:0] rd_mask(input logic [5:0] a);
        case (a)
            ADDR_MINUTES: rd_mask = MASK_MINUTES;
            ADDR_HOURS:   rd_mask = MASK_HOURS;
            ADDR_DOW:     rd_mask = MASK_DOW;
            ADDR_DATE:    rd_mask = MASK_DATE;
            ADDR_MONTH:   rd_mask = MASK_MONTH;
            ADDR_CONTROL: rd_mask = MASK_CONTROL;
            default:      rd_mask = 8'hFF;
        endcase
    endfunction

    always_ff @(posedge link_clk) begin
        if (rst) begin
            ptr_reg <= 6'h00;
            ctl_reg <= RST_CONTROL;
            quiet_reg <= 3'h0;
        end else begin
            if (ptr_load) begin
                ptr_reg <= ptr_value[5:0];
            end else if (wr_valid || rd_next) begin
                ptr_reg <= ptr_reg + 6'h01;
            end
            if (wr_valid && !ptr_load && ptr_reg == ADDR_CONTROL) begin
                ctl_reg <= wr_byte;
            end
            if (ptr_load || wr_valid || rd_next) begin
                quiet_reg <= 3'h0;
            end else if (quiet_reg != 3'h7) begin
                quiet_reg <= quiet_reg + 3'h1;
            end
        end
    end

    // control mirror aged in the core clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctl_s1_reg <= RST_CONTROL;
            ctl_s2_reg <= RST_CONTROL;
            hold_reg <= 5'h00;
        end else begin
            ctl_s1_reg <= ctl_reg;
            ctl_s2_reg <= ctl_s1_reg;
            if (ctl_s1_reg != ctl_s2_reg) begin
                hold_reg <= 5'h00;
            end else if (hold_reg != 5'h1F) begin
                hold_reg <= hold_reg + 5'h01;
            end
        end
    end

    sequence s_time_wr;
        wr_valid && !ptr_load && ptr_reg < ADDR_RAM_LO;
    endsequence

    a_busy_on_write: assert property (@(posedge link_clk) disable iff (rst) s_time_wr |-> ##2 link_busy)
        else $error("time write did not raise busy");
    a_busy_bounded: assert property (@(posedge link_clk) disable iff (rst)
        s_time_wr |-> ##2 link_busy ##[1:20] !link_busy) else $error("busy stuck after time write");
    a_ram_no_busy: assert property (@(posedge link_clk) disable iff (rst)
        wr_valid && !ptr_load && ptr_reg >= ADDR_RAM_LO && !link_busy |=> !link_busy)
        else $error("storage write raised busy");
    a_fixed_zero: assert property (@(posedge link_clk) disable iff (rst)
        quiet_reg >= 3'h2 |-> (rd_byte & ~rd_mask(ptr_reg)) == 8'h00) else $error("fixed zero bit read as one");
    a_ctrl_readback: assert property (@(posedge link_clk) disable iff (rst)
        quiet_reg >= 3'h2 && ptr_reg == ADDR_CONTROL && !link_busy |-> rd_byte == (ctl_reg & MASK_CONTROL))
        else $error("control read back wrong");
    a_pin_level: assert property (@(posedge ref_clk) disable iff (rst)
        hold_reg >= 5'h10 && !ctl_s2_reg[BIT_WAVE_EN] |-> square_wave_oe_n == ctl_s2_reg[BIT_OUT])
        else $error("pin not at output level");
    a_reset_pin: assert property (@(posedge ref_clk) disable iff (rst) $fell(rst) |-> !square_wave_oe_n)
        else $error("pin not low after reset");
    a_data_low: assert property (@(posedge ref_clk) disable iff (rst) !square_wave_o)
        else $error("open drain data not low");
endmodule

bind brtc_core brtc_core_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .osc_in(osc_in), .link_clk(link_clk),
    .bus_start(bus_start), .ptr_load(ptr_load), .ptr_value(ptr_value), .wr_valid(wr_valid), .wr_byte(wr_byte),
    .rd_next(rd_next), .rd_byte(rd_byte), .link_busy(link_busy), .square_wave_o(square_wave_o),
    .square_wave_oe_n(square_wave_oe_n));

// File: test/brtc_bus_master.sv
// two-wire bus master stand-in driving the core's byte-level strobes
// assumes link_clk from the bench; requests change just after a rising edge
`timescale 1ns/1ps
module brtc_bus_master
    import brtc_pkg::*;
(
    input  wire logic       link_clk,  // link clock
    input  wire logic       link_busy, // write crossing
    input  wire logic [7:0] rd_byte,   // byte at pointer
    output logic            bus_start, // start pulse
    output logic            ptr_load,  // address pulse
    output logic      [7:0] ptr_value, // word address
    output logic            wr_valid,  // write pulse
    output logic      [7:0] wr_byte,   // write data
    output logic            rd_next    // read advance
);
    initial begin
        {bus_start, ptr_load, wr_valid, rd_next} = 4'h0;
        ptr_value = 8'h00;
        wr_byte = 8'h00;
    end

    task automatic start();
        @(posedge link_clk);
        bus_start <= 1'b1;
        @(posedge link_clk);
        bus_start <= 1'b0;
        repeat (12) @(posedge link_clk);
    endtask

    // idle byte lanes show the inverse, not a stale value
    task automatic point(input logic [5:0] a);
        @(posedge link_clk);
        ptr_load <= 1'b1;
        ptr_value <= {2'h0, a};
        @(posedge link_clk);
        ptr_load <= 1'b0;
        ptr_value <= ~{2'h0, a};
    endtask

    task automatic wr(input logic [7:0] v);
        repeat (2) @(posedge link_clk);
        while (link_busy) @(posedge link_clk);
        wr_valid <= 1'b1;
        wr_byte <= v;
        @(posedge link_clk);
        wr_valid <= 1'b0;
        wr_byte <= ~v;
    endtask

    task automatic rd(output logic [7:0] v);
        repeat (2) @(posedge link_clk);
        v = rd_byte;
        rd_next <= 1'b1;
        @(posedge link_clk);
        rd_next <= 1'b0;
    endtask
endmodule

// File: test/testbench.sv
// self-checking bench for the bcd timekeeping core
// assumes a fast oscillator (160 ns) and a 4-bit divider so a second is 16 oscillator edges
`timescale 1ns/1ps
module testbench;
    import brtc_pkg::*;
    localparam int OSC_CYC = 20;
    logic       ref_clk, rst, osc_in, link_clk;
    logic       bus_start, ptr_load, wr_valid, rd_next, link_busy, sq_o, sq_oe_n;
    logic [7:0] ptr_value, wr_byte, rd_byte, d;
    int         fails = 0;
    int         checked = 0;
    int         cyc = 0;
    int         per, i, k;
    brtc_time_s t_in[5]  = '{56'h23_04_30_07_23_59_59, 56'h23_02_28_03_23_59_59, 56'h24_02_28_03_23_59_59,
                             56'h99_12_31_07_71_59_59, 56'h05_06_15_02_51_59_59};
    brtc_time_s t_out[5] = '{56'h23_05_01_01_00_00_00, 56'h23_03_01_04_00_00_00, 56'h24_02_29_04_00_00_00,
                             56'h00_01_01_01_52_00_00, 56'h05_06_15_02_72_00_00};

    brtc_core #(.DIV_BITS(4)) dut (.ref_clk(ref_clk), .rst(rst), .osc_in(osc_in), .link_clk(link_clk),
        .bus_start(bus_start), .ptr_load(ptr_load), .ptr_value(ptr_value), .wr_valid(wr_valid),
        .wr_byte(wr_byte), .rd_next(rd_next), .rd_byte(rd_byte), .link_busy(link_busy),
        .square_wave_o(sq_o), .square_wave_oe_n(sq_oe_n));
    brtc_bus_master u_bus (.link_clk(link_clk), .link_busy(link_busy), .rd_byte(rd_byte),
        .bus_start(bus_start), .ptr_load(ptr_load), .ptr_value(ptr_value), .wr_valid(wr_valid),
        .wr_byte(wr_byte), .rd_next(rd_next));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    initial begin
        osc_in = 1'b0;
        forever #80 osc_in = ~osc_in;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fails = fails + 1;
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_per(input int got, input int exp);
        checked++;
        if (got < exp - 3 || got > exp + 3) begin
            fails++;
            $display("BAD %0t period %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
        u_bus.point(a);
        u_bus.wr(v);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        u_bus.start();
        u_bus.point(a);
        u_bus.rd(d);
        chk(d, e);
    endtask

    // ref cycles between two rising pin edges
    task automatic measure(output int p);
        @(posedge sq_oe_n);
        p = cyc;
        @(posedge sq_oe_n);
        p = cyc - p;
    endtask

    initial begin
        rst = 1'b1;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(posedge link_clk);
        for (i = 0; i < 8; i++) rd_chk(6'(i), 8'(64'h03_00_01_01_01_00_00_80 >> (8 * i)));
        chk({7'h00, sq_oe_n}, 8'h00);
        $display("test reset values done");
        u_bus.point(ADDR_RAM_LO);
        for (i = 8; i < 64; i++) u_bus.wr(8'hA5 ^ 8'(i));
        u_bus.wr(8'h00);
        u_bus.start();
        u_bus.point(ADDR_RAM_LO);
        for (i = 8; i < 64; i++) begin
            u_bus.rd(d);
            chk(d, 8'hA5 ^ 8'(i));
        end
        u_bus.rd(d);
        chk(d, 8'h00);
        $display("test storage and wrap done");
        wr_reg(ADDR_CONTROL, 8'hFF);
        rd_chk(ADDR_CONTROL, 8'h93);
        for (i = 0; i < 4; i++) begin
            wr_reg(ADDR_CONTROL, 8'h10 | 8'(i));
            repeat (400) @(posedge ref_clk);
            measure(per);
            if (i == 0) chk_per(per, OSC_CYC << 4);
            if (i == 1) chk_per(per, OSC_CYC << (TAP_4K + 1));
            if (i == 2) chk_per(per, OSC_CYC << (TAP_8K + 1));
            if (i == 3) chk_per(per, OSC_CYC);
        end
        wr_reg(ADDR_CONTROL, 8'h80);
        repeat (60) @(posedge ref_clk);
        chk({7'h00, sq_oe_n}, 8'h01);
        wr_reg(ADDR_CONTROL, 8'h03);
        repeat (60) @(posedge ref_clk);
        chk({7'h00, sq_oe_n}, 8'h00);
        $display("test square wave done");
        wr_reg(ADDR_SECONDS, 8'hA5);
        repeat (700) @(posedge ref_clk);
        rd_chk(ADDR_SECONDS, 8'hA5);
        wr_reg(ADDR_SECONDS, 8'h25);
        repeat (400) @(posedge ref_clk);
        rd_chk(ADDR_SECONDS, 8'h26);
        $display("test halt done");
        for (i = 0; i < 5; i++) begin
            u_bus.point(ADDR_SECONDS);
            for (k = 0; k < 7; k++) u_bus.wr(t_in[i][8 * k +: 8]);
            rd_chk(ADDR_SECONDS, t_in[i].seconds);
            repeat (300) @(posedge ref_clk);
            u_bus.start();
            u_bus.point(ADDR_SECONDS);
            for (k = 0; k < 7; k++) begin
                u_bus.rd(d);
                chk(d, t_out[i][8 * k +: 8]);
            end
        end
        $display("test rollover done");
        stop_test();
    end
endmodule
